// ### verilog/dsid_decoder.sv
// instruction format decoder with avalon-mm register access.
// software writes an instruction word, the block decodes it, runs its cycle
// count and reports operands, cycles and the status flags it holds.
// assumes one 100 mhz clock and an avalon master that honours waitrequest.
`timescale 1ns/1ps
`include "dsid_defines.svh"
module dsid_decoder
  import dsid_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic [`DSID_ADDR_W-1:0]  avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  input  wire logic                     skip_taken,
  input  wire logic                     cond_true,
  input  wire logic [3:0]               base_reg_value,
  input  wire dsid_flags_t              flags_in,
  input  wire logic                     flags_we,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  output logic                          exec_valid,
  output logic                          nop_cycle,
  output logic [3:0]                    eff_bit_num,
  output dsid_flags_t                   flags_out
);

  // decode of one word; also used for the second word of a double-word instruction, which decodes as a nop
  function automatic dsid_dec_t decode(input logic [23:0] iw, input logic second);
    dsid_dec_t d;
    logic [7:0] op;
    d = '0;
    op = iw[`DSID_OPC_MSB:`DSID_OPC_LSB];
    d.opcode          = op;
    d.base_work_reg   = iw[`DSID_BASE_LSB+:4];
    d.source_work_reg = iw[`DSID_SREG_LSB+:4];
    d.source_mode     = iw[`DSID_SMODE_LSB+:3];
    d.dest_work_reg   = iw[`DSID_DREG_LSB+3+:4];
    d.dest_mode       = iw[`DSID_DMODE_LSB+3+:3];
    d.file_addr       = iw[`DSID_FADDR_W-1:0];
    d.dest_is_file    = iw[`DSID_FDIR_BIT];
    d.bit_select_field = iw[`DSID_BITSEL_LSB+:4];
    d.bit_from_reg    = iw[`DSID_BIT_IND_BIT];
    d.ten_bit_literal = iw[`DSID_TEN_BIT_LITERAL_LSB+:10];
    d.lit_range_err   = (op == `DSID_OPC_ADDL) && iw[`DSID_BYTE_BIT]
                        && (d.ten_bit_literal > `DSID_BYTE_MAX);
    if (op == `DSID_OPC_MOVL23)
    begin
      d.lit_range_err = iw[0];
    end
    // only three opcodes use a second word
    d.is_double = (op == `DSID_OPC_CALL2) || (op == `DSID_OPC_GOTO2)
                  || (op == `DSID_OPC_MOVD2);
    d.is_nop = second || (op == `DSID_OPC_NOP2);
    case (op)
      `DSID_OPC_CALL2, `DSID_OPC_GOTO2, `DSID_OPC_MOVD2:
        d.cycles = `DSID_CYC_TWO;
      `DSID_OPC_BRA, `DSID_OPC_IND_CG, `DSID_OPC_TBL:
        d.cycles = `DSID_CYC_TWO;
      `DSID_OPC_RET, `DSID_OPC_RETI:
        d.cycles = `DSID_CYC_THREE;
      default:
        d.cycles = `DSID_CYC_ONE;
    endcase
    if (second)
    begin
      d.cycles = `DSID_CYC_ONE;
      d.is_double = 1'b0;
    end
    return d;
  endfunction

  dsid_state_t state_q;
  logic [23:0] word_q;
  logic        second_q;
  logic        start_q;
  logic        skip_dbl_q;
  logic [1:0]  cyc_left_q;
  logic [7:0]  word_op;
  logic        is_mac;
  logic        is_shift;
  logic [1:0]  awb_sel;
  logic        mac_q;
  logic        acc_b_q;
  logic        shift_lit_q;
  logic [3:0]  shift_amt_q;
  logic [3:0]  awb_reg_q;
  logic [3:0]  awb_step_q;
  dsid_dec_t   dec_q;
  dsid_flags_t flags_q;
  logic [3:0]  eff_bit_q;
  logic        valid_q;
  logic        nop_q;
  logic [31:0] rdata_q;
  logic        wait_q;
  dsid_dec_t   dec_d;
  logic        busy;

  assign dec_d = decode(word_q, second_q);
  assign busy  = (state_q != DSID_ST_IDLE);

  // dsp fields read straight from the stored word; a second word carries none
  assign word_op  = word_q[`DSID_OPC_MSB:`DSID_OPC_LSB];
  assign is_mac   = (word_op == `DSID_OPC_MAC) && !second_q;
  assign is_shift = (word_op == `DSID_OPC_SHIFT) && !second_q;
  assign awb_sel  = is_mac ? word_q[`DSID_AWB_LSB+:2] : 2'h0;

  // bus slave: one wait cycle per access, answer on the following edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= !(wait_q && (avs_read || avs_write));
      if (avs_read && wait_q)
      begin
        case (avs_address)
          `DSID_REG_CTRL:  rdata_q <= {8'h00, awb_step_q, awb_reg_q, shift_amt_q, 1'b0,
                                       shift_lit_q, acc_b_q, mac_q, 5'h00,
                                       skip_dbl_q, second_q, busy};
          `DSID_REG_WORD:  rdata_q <= {8'h00, word_q};
          `DSID_REG_DEC:   rdata_q <= {dec_q.opcode, dec_q.base_work_reg,
                                       dec_q.source_work_reg, dec_q.dest_work_reg,
                                       dec_q.bit_select_field, dec_q.lit_range_err,
                                       dec_q.is_double, dec_q.is_nop,
                                       dec_q.dest_is_file, dec_q.cycles, 2'h0};
          `DSID_REG_FLAGS: rdata_q <= {23'h00_0000, flags_q};
          default:         rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // instruction word capture; control writes start execution.
  // a write lands on the edge after its wait cycle, while waitrequest is low, so a stalled request changes nothing
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      word_q     <= 24'h00_0000;
      second_q   <= 1'b0;
      start_q    <= 1'b0;
      skip_dbl_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      if (avs_write && !wait_q && !busy)
      begin
        if (avs_address == `DSID_REG_WORD && avs_byteenable[2:0] == 3'h7)
        begin
          word_q <= avs_writedata[23:0];
        end
        if (avs_address == `DSID_REG_CTRL && avs_byteenable[0])
        begin
          second_q   <= avs_writedata[1];
          skip_dbl_q <= avs_writedata[2];
          start_q    <= avs_writedata[0];
        end
      end
    end
  end

  // execution sequencer: first cycle does work, extra cycles are bubbles
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q    <= DSID_ST_IDLE;
      cyc_left_q <= 2'h0;
      dec_q      <= '0;
      valid_q    <= 1'b0;
      nop_q      <= 1'b0;
      eff_bit_q  <= 4'h0;
    end
    else
    begin
      valid_q <= 1'b0;
      nop_q   <= 1'b0;
      case (state_q)
        DSID_ST_IDLE:
        begin
          if (start_q)
          begin
            dec_q   <= dec_d;
            state_q <= DSID_ST_EXEC;
          end
        end
        DSID_ST_EXEC:
        begin
          valid_q   <= !dec_q.is_nop;
          nop_q     <= dec_q.is_nop;
          eff_bit_q <= dec_q.bit_from_reg ? base_reg_value
                                          : dec_q.bit_select_field;
          if (dec_q.opcode == `DSID_OPC_SKIP && skip_taken)
          begin
            cyc_left_q <= skip_dbl_q ? 2'h2 : 2'h1;
          end
          else if (dec_q.opcode == `DSID_OPC_CBRA && cond_true)
          begin
            cyc_left_q <= 2'h1;
          end
          else
          begin
            cyc_left_q <= dec_q.cycles - 2'h1;
          end
          state_q <= DSID_ST_WAIT2;
        end
        DSID_ST_WAIT2:
        begin
          if (cyc_left_q == 2'h0)
          begin
            state_q <= DSID_ST_IDLE;
          end
          else
          begin
            state_q <= DSID_ST_NOP;
          end
        end
        DSID_ST_NOP:
        begin
          nop_q      <= 1'b1;
          cyc_left_q <= cyc_left_q - 2'h1;
          if (cyc_left_q == 2'h1)
          begin
            state_q <= DSID_ST_IDLE;
          end
        end
        default:
        begin
          state_q <= DSID_ST_IDLE;
        end
      endcase
    end
  end

  // dsp operand capture; held after the run so software can read it back
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mac_q       <= 1'b0;
      acc_b_q     <= 1'b0;
      shift_lit_q <= 1'b0;
      shift_amt_q <= 4'h0;
      awb_reg_q   <= 4'h0;
      awb_step_q  <= 4'h0;
    end
    else if (state_q == DSID_ST_IDLE && start_q)
    begin
      mac_q       <= is_mac;
      acc_b_q     <= is_mac && word_q[`DSID_ACC_SEL_BIT];
      shift_lit_q <= is_shift && word_q[`DSID_SHIFT_LIT_BIT];
      awb_reg_q   <= (awb_sel == `DSID_AWB_DIRECT || awb_sel == `DSID_AWB_POSTINC)
                     ? `DSID_AWB_REG : 4'h0;
      awb_step_q  <= (awb_sel == `DSID_AWB_POSTINC) ? `DSID_AWB_STEP : 4'h0;
    end
    else if (state_q == DSID_ST_EXEC && dec_q.opcode == `DSID_OPC_SHIFT && !dec_q.is_nop)
    begin
      // register contents are only offered in the working cycle, as for the bit number
      shift_amt_q <= shift_lit_q ? word_q[`DSID_SHIFT_AMT_LSB+:4] : base_reg_value;
    end
  end

  // flags: updated only on a working cycle, never on a bubble
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_q <= `DSID_FLAG_RST;
    end
    else if (flags_we && valid_q)
    begin
      flags_q <= flags_in;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign exec_valid      = valid_q;
  assign nop_cycle       = nop_q;
  assign eff_bit_num     = eff_bit_q;
  assign flags_out       = flags_q;

  // a bubble cycle never reports work
  chk_nop_no_work: assert property (@(posedge clk) disable iff (!arst_n)
    !(nop_q && valid_q)) else $error("nop and valid together");

  // a second word alone decodes as no-operation
  chk_second_word_nop: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == DSID_ST_EXEC && second_q) |=> nop_q) else $error("second word not nop");

  // three-cycle return: exec then two bubbles
  chk_return_cycles: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == DSID_ST_EXEC && dec_q.opcode == `DSID_OPC_RET && !dec_q.is_nop)
    |=> ##1 (state_q == DSID_ST_NOP) ##1 (state_q == DSID_ST_NOP) ##1 (state_q == DSID_ST_IDLE))
    else $error("return cycle count wrong");

  // double-word instruction takes one extra bubble
  chk_double_cycles: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == DSID_ST_EXEC && dec_q.is_double)
    |=> ##1 (state_q == DSID_ST_NOP) ##1 (state_q == DSID_ST_IDLE))
    else $error("double word cycle count wrong");

  // skip over two words gives two bubbles
  chk_skip_double: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == DSID_ST_EXEC && dec_q.opcode == `DSID_OPC_SKIP && skip_taken && skip_dbl_q)
    |=> cyc_left_q == 2'h2) else $error("skip cycles wrong");

  // plain single cycle returns to idle without bubble
  chk_single_cycle: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == DSID_ST_EXEC && dec_q.cycles == `DSID_CYC_ONE
     && dec_q.opcode != `DSID_OPC_SKIP && dec_q.opcode != `DSID_OPC_CBRA)
    |=> ##1 (state_q == DSID_ST_IDLE)) else $error("single cycle overran");

  // flags hold on bubble cycles
  chk_flags_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !valid_q |=> $stable(flags_q)) else $error("flags changed without work");

  // indirect bit number taken from base register
  chk_bit_source: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == DSID_ST_EXEC && dec_q.bit_from_reg)
    |=> eff_bit_q == $past(base_reg_value)) else $error("bit number source wrong");

  // skip over one word gives a single bubble
  chk_skip_single: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == DSID_ST_EXEC && dec_q.opcode == `DSID_OPC_SKIP && skip_taken && !skip_dbl_q)
    |=> cyc_left_q == 2'h1) else $error("single skip cycles wrong");

  // shift amount from a register comes from the base register value
  chk_shift_source: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == DSID_ST_EXEC && dec_q.opcode == `DSID_OPC_SHIFT && !dec_q.is_nop
     && !shift_lit_q)
    |=> shift_amt_q == $past(base_reg_value)) else $error("shift amount source wrong");

  // write-back target is register 13 or nothing, and a step needs the target
  chk_awb_target: assert property (@(posedge clk) disable iff (!arst_n)
    (awb_reg_q == `DSID_AWB_REG || (awb_reg_q == 4'h0 && awb_step_q == 4'h0)))
    else $error("write-back target wrong");

  // accumulator b may only be chosen by a multiply-accumulate word
  chk_acc_needs_mac: assert property (@(posedge clk) disable iff (!arst_n)
    acc_b_q |-> mac_q) else $error("accumulator select without mac");

endmodule

// ### verilog/dsid_defines.svh
// constants for the instruction format decoder: field positions, widths,
// opcode classes, cycle counts and the register map of the decoder block.
// assumes an avalon-mm slave with 32-bit data and word-aligned byte addresses.
`ifndef DSID_DEFINES_SVH
`define DSID_DEFINES_SVH

// instruction word layout
`define DSID_IW_W         24
`define DSID_OPC_MSB      23
`define DSID_OPC_LSB      16
`define DSID_BASE_LSB     11
`define DSID_DMODE_LSB    7
`define DSID_DREG_LSB     4
`define DSID_SREG_LSB     0
`define DSID_SMODE_LSB    4
`define DSID_BYTE_BIT     14
`define DSID_FDIR_BIT     13
`define DSID_FADDR_W      13
`define DSID_BITSEL_LSB   12
`define DSID_TEN_BIT_LITERAL_LSB    4
`define DSID_BIT_IND_BIT  7
`define DSID_SHIFT_LIT_BIT 15
`define DSID_SHIFT_AMT_LSB 0
`define DSID_ACC_SEL_BIT  15
`define DSID_AWB_LSB      0
`define DSID_AWB_DIRECT   2'h1
`define DSID_AWB_POSTINC  2'h2
`define DSID_AWB_STEP     4'h2
`define DSID_AWB_REG      4'hd
`define DSID_BYTE_MAX     10'h0ff

// opcode classes (top byte)
`define DSID_OPC_NOP2     8'h00
`define DSID_OPC_CALL2    8'h02
`define DSID_OPC_GOTO2    8'h04
`define DSID_OPC_MOVD2    8'h08
`define DSID_OPC_BRA      8'h37
`define DSID_OPC_IND_CG   8'h01
`define DSID_OPC_TBL      8'hba
`define DSID_OPC_RET      8'h06
`define DSID_OPC_RETI     8'h07
`define DSID_OPC_SKIP     8'haf
`define DSID_OPC_CBRA     8'h30
`define DSID_OPC_ADDW     8'h40
`define DSID_OPC_ADDF     8'hb4
`define DSID_OPC_ADDL     8'hb0
`define DSID_OPC_BITOP    8'ha0
`define DSID_OPC_MAC      8'hc0
`define DSID_OPC_SHIFT    8'hc8
`define DSID_OPC_MOVL23   8'h09

// cycle counts
`define DSID_CYC_ONE      2'h1
`define DSID_CYC_TWO      2'h2
`define DSID_CYC_THREE    2'h3

// register map, byte addresses (word index << 2)
`define DSID_ADDR_W       4
`define DSID_REG_CTRL     4'h0
`define DSID_REG_WORD     4'h4
`define DSID_REG_DEC      4'h8
`define DSID_REG_FLAGS    4'hc
`define DSID_CTRL_RST     32'h0000_0000
`define DSID_FLAG_RST     9'h000

`endif

// ### verilog/dsid_pkg.sv
// types shared by the instruction format decoder.
// assumes dsid_defines.svh is on the include path.
package dsid_pkg;
  `include "dsid_defines.svh"

  typedef enum logic [3:0]
  {
    DSID_ST_IDLE  = 4'b0001,
    DSID_ST_EXEC  = 4'b0010,
    DSID_ST_NOP   = 4'b0100,
    DSID_ST_WAIT2 = 4'b1000
  } dsid_state_t;

  // decoded operand fields of one instruction word
  typedef struct packed
  {
    logic [7:0]  opcode;
    logic [3:0]  base_work_reg;
    logic [3:0]  source_work_reg;
    logic [2:0]  source_mode;
    logic [3:0]  dest_work_reg;
    logic [2:0]  dest_mode;
    logic [12:0] file_addr;
    logic        dest_is_file;
    logic [3:0]  bit_select_field;
    logic        bit_from_reg;
    logic [9:0]  ten_bit_literal;
    logic        lit_range_err;
    logic        is_nop;
    logic        is_double;
    logic [1:0]  cycles;
  } dsid_dec_t;

  // status flags kept by the core
  typedef struct packed
  {
    logic acc_a_overflow_flag;
    logic acc_b_overflow_flag;
    logic acc_a_saturate_flag;
    logic acc_b_saturate_flag;
    logic carry_flag;
    logic digit_carry_flag;
    logic negative_flag;
    logic overflow_flag;
    logic sticky_zero_flag;
  } dsid_flags_t;
endpackage

// ### verif/dsid_exec_model.sv
// model of the fetch unit and execution datapath around the decoder.
// assumes the bench sets the cfg inputs while the decoder is idle.
`timescale 1ns/1ps
module dsid_exec_model
  import dsid_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cfg_skip,
  input  wire logic        cfg_cond,
  input  wire logic [3:0]  cfg_base,
  input  wire logic [8:0]  cfg_flags,
  output logic             skip_taken,
  output logic             cond_true,
  output logic [3:0]       base_reg_value,
  output dsid_flags_t      flags_in,
  output logic             flags_we
);
  // datapath offers flags every cycle, so the decoder has to gate the load itself
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      skip_taken     <= 1'b0;
      cond_true      <= 1'b0;
      base_reg_value <= 4'h0;
      flags_in       <= '0;
      flags_we       <= 1'b0;
    end
    else
    begin
      skip_taken     <= cfg_skip;
      cond_true      <= cfg_cond;
      base_reg_value <= cfg_base;
      flags_in       <= cfg_flags;
      flags_we       <= 1'b1;
    end
  end
endmodule

// ### verif/testbench.sv
// self-checking bench for the instruction format decoder.
// assumes the decoder answers each avalon access after one wait cycle.
`timescale 1ns/1ps
`include "dsid_defines.svh"
module testbench
  import dsid_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, cfg_base = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic cfg_skip = 1'b0, cfg_cond = 1'b0, avs_waitrequest, exec_valid, nop_cycle;
  logic skip_taken, cond_true, flags_we;
  logic [3:0] base_reg_value, eff_bit_num;
  logic [8:0] cfg_flags = 9'h000;
  dsid_flags_t flags_in, flags_out;
  int n_mismatch = 0, checked = 0, n_exec = 0, n_nop = 0;

  always #5 clk = ~clk;

  dsid_decoder dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .skip_taken(skip_taken), .cond_true(cond_true),
    .base_reg_value(base_reg_value), .flags_in(flags_in), .flags_we(flags_we),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .exec_valid(exec_valid), .nop_cycle(nop_cycle), .eff_bit_num(eff_bit_num),
    .flags_out(flags_out));

  dsid_exec_model partner (.clk(clk), .arst_n(arst_n), .cfg_skip(cfg_skip),
    .cfg_cond(cfg_cond), .cfg_base(cfg_base), .cfg_flags(cfg_flags),
    .skip_taken(skip_taken), .cond_true(cond_true), .base_reg_value(base_reg_value),
    .flags_in(flags_in), .flags_we(flags_we));

  // count working and bubble cycles of the current run
  always @(posedge clk)
  begin
    if (exec_valid === 1'b1) n_exec++;
    if (nop_cycle === 1'b1) n_nop++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    begin
      checked++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
    end
  endtask

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    begin
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      k = 0;
      do begin @(posedge clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50) chk(1, 0, "bus hang");
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask

  // start one instruction, wait for idle, compare pulse counts and decode bits
  task automatic run(input logic [23:0] w, input logic [1:0] c, input int ex,
                     input int np, input logic [7:0] dx, input logic [7:0] mk);
    logic [31:0] q;
    int k;
    begin
      bus(1'b1, `DSID_REG_WORD, {8'h00, w}, q);
      n_exec = 0;
      n_nop = 0;
      bus(1'b1, `DSID_REG_CTRL, {29'h0, c, 1'b1}, q);
      k = 0;
      do begin bus(1'b0, `DSID_REG_CTRL, 32'h0, q); k++; end while (q[0] !== 1'b0 && k < 20);
      if (q[0] !== 1'b0) chk(1, 0, "busy hang");
      chk(n_exec, ex, "working cycles");
      chk(n_nop, np, "bubble cycles");
      bus(1'b0, `DSID_REG_DEC, 32'h0, q);
      chk({q[31:24], q[7:0] & mk}, {w[23:16], dx & mk}, "decode word");
    end
  endtask

  task automatic t_reset;
    logic [31:0] q;
    begin
      bus(1'b0, `DSID_REG_CTRL, 32'h0, q);
      chk(q, `DSID_CTRL_RST, "ctrl reset");
      bus(1'b0, `DSID_REG_FLAGS, 32'h0, q);
      chk(q, {23'h0, `DSID_FLAG_RST}, "flags reset");
      bus(1'b0, 4'h1, 32'h0, q);
      chk(q, 32'h0000_0000, "unmapped read");
      $display("test reset done");
    end
  endtask

  task automatic t_cycles;
    logic [31:0] q;
    begin
      run(24'h40_000f, 2'b00, 1, 0, 8'h04, 8'hec);
      bus(1'b0, `DSID_REG_DEC, 32'h0, q);
      chk(q[19:16], 4'hf, "source register");
      run(24'h37_0000, 2'b00, 1, 1, 8'h08, 8'hec);
      run(24'h01_0000, 2'b00, 1, 1, 8'h08, 8'hec);
      run(24'hba_0000, 2'b00, 1, 1, 8'h08, 8'hec);
      run(24'h06_0000, 2'b00, 1, 2, 8'h0c, 8'hec);
      run(24'h07_0000, 2'b00, 1, 2, 8'h0c, 8'hec);
      run(24'h02_0000, 2'b00, 1, 1, 8'h48, 8'hec);
      run(24'h04_0000, 2'b00, 1, 1, 8'h48, 8'hec);
      run(24'h08_0000, 2'b00, 1, 1, 8'h48, 8'hec);
      run(24'hb4_2000, 2'b00, 1, 0, 8'h14, 8'hec);
      run(24'h00_0000, 2'b00, 0, 1, 8'h24, 8'hec);
      run(24'h00_1234, 2'b01, 0, 1, 8'h24, 8'h60);
      run(24'h30_0000, 2'b00, 1, 0, 8'h04, 8'h00);
      cfg_cond <= 1'b1;
      run(24'h30_0000, 2'b00, 1, 1, 8'h08, 8'h00);
      cfg_cond <= 1'b0;
      cfg_skip <= 1'b1;
      run(24'haf_0000, 2'b00, 1, 1, 8'h08, 8'h00);
      run(24'haf_0000, 2'b10, 1, 2, 8'h0c, 8'h00);
      cfg_skip <= 1'b0;
      $display("test cycles done");
    end
  endtask

  task automatic t_operands;
    begin
      run(24'hb0_5000, 2'b00, 1, 0, 8'h80, 8'h80);
      run(24'hb0_4ff0, 2'b00, 1, 0, 8'h00, 8'h80);
      run(24'hb0_3ff0, 2'b00, 1, 0, 8'h00, 8'h80);
      run(24'h09_0001, 2'b00, 1, 0, 8'h80, 8'h80);
      run(24'h09_0002, 2'b00, 1, 0, 8'h00, 8'h80);
      run(24'ha0_5000, 2'b00, 1, 0, 8'h00, 8'h00);
      chk(eff_bit_num, 4'h5, "literal bit number");
      run(24'ha0_f000, 2'b00, 1, 0, 8'h00, 8'h00);
      chk(eff_bit_num, 4'hf, "top literal bit number");
      cfg_base <= 4'ha;
      run(24'ha0_0080, 2'b00, 1, 0, 8'h00, 8'h00);
      chk(eff_bit_num, 4'ha, "register bit number");
      $display("test operands done");
    end
  endtask

  task automatic t_flags;
    logic [31:0] q;
    begin
      cfg_flags <= 9'h1a5;
      run(24'h40_0000, 2'b00, 1, 0, 8'h04, 8'h00);
      bus(1'b0, `DSID_REG_FLAGS, 32'h0, q);
      chk(q, 32'h0000_01a5, "flags after work");
      cfg_flags <= 9'h05a;
      run(24'h00_0000, 2'b00, 0, 1, 8'h00, 8'h00);
      chk(flags_out, 9'h1a5, "flags after bubble");
      $display("test flags done");
    end
  endtask

  task automatic t_dsp;
    logic [31:0] q;
    begin
      run(24'hc0_8002, 2'b00, 1, 0, 8'h04, 8'hec);
      bus(1'b0, `DSID_REG_CTRL, 32'h0, q);
      chk({q[23:16], q[11:8]}, {8'h2d, 4'h3}, "mac acc b post-inc");
      run(24'hc0_0001, 2'b00, 1, 0, 8'h04, 8'hec);
      bus(1'b0, `DSID_REG_CTRL, 32'h0, q);
      chk({q[23:16], q[11:8]}, {8'h0d, 4'h1}, "mac acc a direct");
      run(24'hc8_8007, 2'b00, 1, 0, 8'h04, 8'hec);
      bus(1'b0, `DSID_REG_CTRL, 32'h0, q);
      chk(q[23:8], 16'h0074, "shift literal");
      cfg_base <= 4'h9;
      run(24'hc8_0007, 2'b00, 1, 0, 8'h04, 8'hec);
      bus(1'b0, `DSID_REG_CTRL, 32'h0, q);
      chk(q[23:8], 16'h0090, "shift register");
      $display("test dsp done");
    end
  endtask

  task automatic stop_test;
    begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  // watchdog: a full run takes a few hundred cycles
  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_cycles();
    t_operands();
    t_flags();
    t_dsp();
    stop_test();
  end
endmodule
